//--- ocp_top.sv
`timescale 1ns/1ps
module ocp_top #(
   parameter int unsigned WDOG_CYCLES  = ocp_pkg::WDOG_CYCLES,
   parameter int unsigned FLASH_CYCLES = ocp_pkg::FLASH_CYCLES
) (
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_entry_left,
   input  wire logic        i_entry_right,
   input  wire logic        i_start_sw,
   input  wire logic        i_stop_sw,
   input  wire logic        i_ack_sw,
   input  wire logic        i_silence_sw,
   input  wire logic        i_manual_reset,
   input  wire logic        i_wdog_kick,
   input  wire logic        i_input_idle,
   input  wire logic        i_service_msg,
   input  wire logic        i_transfer_done,
   input  wire logic [11:0] i_lamp_sw,
   input  wire logic [2:0]  i_chan_fail,
   input  wire logic [15:0] i_select_sw,
   output logic             o_entry_req,
   output logic             o_start_req,
   output logic             o_monitor_fail_lamp,
   output logic      [2:0]  o_chan_alarm_lamp,
   output logic      [2:0]  o_chan_answer,
   output logic             o_audible_alarm,
   output logic             o_ack_lamp,
   output logic      [2:0]  o_restart_lamp,
   output logic      [11:0] o_alarm_lamp
);
   typedef struct packed {
      ocp_pkg::ocp_panel_t prev;
      logic                armed;
      logic                start_cap;
      logic                stop_cap;
      logic [1:0]          snap;
      logic                entry_pend;
      logic                entry_req;
      logic                start_req;
      logic [15:0]         sel_snap;
      logic [31:0]         wdog_cnt;
      logic                mon_fail;
      logic [2:0]          chan_alarm;
      logic [2:0]          chan_answer;
      logic                alarm_ff;
      logic                audible;
      logic                ack_lamp;
      logic [2:0]          svc_lamp;
      logic [2:0]          svc_snap;
      logic                matrix_armed;
      logic                clear_stb;
      logic                load_stb;
      logic [11:0]         word;
      logic [31:0]         flash_cnt;
      logic                blink;
      logic [11:0]         lamp_out;
      logic                wb_ack;
      logic [31:0]         wb_dat;
   } ocp_state_t;

   ocp_pkg::ocp_panel_t raw;
   ocp_pkg::ocp_panel_t sw;
   ocp_state_t          r_r;
   ocp_state_t          r_nxt;
   logic [11:0]         lamp_lit;
   logic [11:0]         lamp_flash;
   logic [11:0]         lamp_steady;
   logic [11:0]         press;
   logic                both;
   logic                req;
   logic                wr;
   logic                fsc_wr;
   logic                word_wr;
   logic [15:0]         code;
   logic                new_lamp;
   logic                alarm_set;
   logic [31:0]         rd_data;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] tgt);
      return a == tgt;
   endfunction

   function automatic logic is_code(input logic [15:0] c,
                                    input logic [15:0] tgt);
      return c == tgt;
   endfunction

   assign raw = '{entry_l:   i_entry_left,
                  entry_r:   i_entry_right,
                  start:     i_start_sw,
                  stop:      i_stop_sw,
                  ack:       i_ack_sw,
                  silence:   i_silence_sw,
                  man_reset: i_manual_reset,
                  wdog_kick: i_wdog_kick,
                  idle:      i_input_idle,
                  svc_msg:   i_service_msg,
                  xfer_done: i_transfer_done,
                  lamp_sw:   i_lamp_sw,
                  chan_fail: i_chan_fail,
                  sel:       i_select_sw};

   // every panel pin is asynchronous to the system clock
   ocp_sync #(
      .WIDTH ($bits(ocp_pkg::ocp_panel_t))
   ) u_sync (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_d     (raw),
      .o_q     (sw)
   );

   assign both    = sw.entry_l && sw.entry_r;
   assign req     = i_wb_cyc && i_wb_stb && !r_r.wb_ack;
   // written registers are 16 bits or less; low two byte lanes must both be set
   assign wr      = req && i_wb_we && (i_wb_sel[1:0] == 2'b11);
   assign fsc_wr  = wr && hit(i_wb_adr, ocp_pkg::ADR_FSC);
   assign word_wr = wr && hit(i_wb_adr, ocp_pkg::ADR_ALARM);
   assign code    = i_wb_dat[15:0];
   assign press   = sw.lamp_sw & ~r_r.prev.lamp_sw;

   for (genvar g = 0; g < ocp_pkg::LAMP_W; g++) begin : g_lamp
      ocp_lamp u_lamp (
         .i_clock  (i_clock),
         .i_rstn   (i_rstn),
         .i_clear  (r_r.clear_stb),
         .i_load   (r_r.load_stb),
         .i_bit    (r_r.word[g]),
         .i_press  (press[g]),
         .i_blink  (r_r.blink),
         .o_lit    (lamp_lit[g]),
         .o_flash  (lamp_flash[g]),
         .o_steady (lamp_steady[g])
      );
   end

   always_comb begin
      r_nxt             = r_r;
      new_lamp          = 1'b0;
      alarm_set         = 1'b0;
      rd_data           = ocp_pkg::RST_WORD;
      r_nxt.prev        = sw;
      r_nxt.entry_req   = 1'b0;
      r_nxt.start_req   = 1'b0;
      r_nxt.clear_stb   = 1'b0;
      r_nxt.load_stb    = 1'b0;

      // clears come first so that a set in the same cycle wins
      if (fsc_wr && is_code(code, ocp_pkg::FSC_GATE_OUT_STATUS)) begin
         r_nxt.start_cap  = 1'b0;
         r_nxt.stop_cap   = 1'b0;
         r_nxt.snap       = 2'b00;
         r_nxt.entry_pend = 1'b0;
      end
      if (sw.start && !r_r.prev.start) begin
         r_nxt.start_cap = 1'b1;
         r_nxt.start_req = 1'b1;
      end
      if (sw.stop && !r_r.prev.stop) begin
         r_nxt.stop_cap = 1'b1;
      end

      if (!both) begin
         r_nxt.armed = 1'b1;
      end else if (r_r.armed) begin
         r_nxt.armed      = 1'b0;
         r_nxt.entry_req  = 1'b1;
         r_nxt.entry_pend = 1'b1;
         r_nxt.snap       = {r_r.stop_cap, r_r.start_cap};
         r_nxt.sel_snap   = sw.sel;
      end

      if (sw.wdog_kick && !r_r.prev.wdog_kick) begin
         r_nxt.wdog_cnt = ocp_pkg::RST_WORD;
         r_nxt.mon_fail = 1'b0;
      end else if (r_r.wdog_cnt == 32'(WDOG_CYCLES - 1)) begin
         r_nxt.mon_fail = 1'b1;
      end else begin
         r_nxt.wdog_cnt = r_r.wdog_cnt + 32'h0000_0001;
      end

      // only the manual reset pin clears these; no bus path reaches them
      if (sw.man_reset) begin
         r_nxt.chan_alarm = 3'b000;
      end
      r_nxt.chan_answer = sw.chan_fail & ~r_r.prev.chan_fail;
      r_nxt.chan_alarm  = r_nxt.chan_alarm | r_nxt.chan_answer;

      new_lamp  = r_r.load_stb && |(r_r.word & ~(lamp_flash | lamp_steady));
      alarm_set = |r_nxt.chan_answer || (r_nxt.mon_fail && !r_r.mon_fail) ||
                  new_lamp;
      if (sw.ack) begin
         r_nxt.alarm_ff = 1'b0;
      end
      if (alarm_set) begin
         r_nxt.alarm_ff = 1'b1;
      end
      r_nxt.audible  = r_nxt.alarm_ff && !sw.silence;
      r_nxt.ack_lamp = sw.ack;

      r_nxt.svc_lamp = {sw.xfer_done, sw.idle, sw.svc_msg};
      if (fsc_wr && is_code(code, ocp_pkg::FSC_GATE_IN_SERVICE)) begin
         r_nxt.svc_snap = r_r.svc_lamp;
      end

      if (fsc_wr && is_code(code, ocp_pkg::FSC_GATE_IN_ALARM)) begin
         r_nxt.clear_stb    = 1'b1;
         r_nxt.matrix_armed = 1'b1;
      end
      // a word without a preceding matrix code is ignored
      if (word_wr && r_r.matrix_armed) begin
         r_nxt.load_stb     = 1'b1;
         r_nxt.word         = i_wb_dat[11:0];
         r_nxt.matrix_armed = 1'b0;
      end

      if (r_r.flash_cnt == 32'(FLASH_CYCLES - 1)) begin
         r_nxt.flash_cnt = ocp_pkg::RST_WORD;
         r_nxt.blink     = !r_r.blink;
      end else begin
         r_nxt.flash_cnt = r_r.flash_cnt + 32'h0000_0001;
      end
      r_nxt.lamp_out = lamp_lit;

      case (i_wb_adr)
         ocp_pkg::ADR_ALARM: begin
            rd_data = {4'h0, lamp_flash, 4'h0, lamp_steady};
         end
         ocp_pkg::ADR_STATUS: begin
            rd_data = {22'h000000, r_r.matrix_armed, sw.silence, r_r.alarm_ff,
                       r_r.chan_alarm, r_r.mon_fail, r_r.entry_pend,
                       r_r.snap};
         end
         ocp_pkg::ADR_SERVICE: begin
            rd_data = {29'h00000000, r_r.svc_snap};
         end
         ocp_pkg::ADR_SWITCH: begin
            rd_data = {16'h0000, r_r.sel_snap};
         end
         default: begin
            rd_data = ocp_pkg::RST_WORD;
         end
      endcase
      r_nxt.wb_ack = req;
      if (req) begin
         r_nxt.wb_dat = i_wb_we ? ocp_pkg::RST_WORD : rd_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign o_wb_dat            = r_r.wb_dat;
   assign o_wb_ack            = r_r.wb_ack;
   assign o_entry_req         = r_r.entry_req;
   assign o_start_req         = r_r.start_req;
   assign o_monitor_fail_lamp = r_r.mon_fail;
   assign o_chan_alarm_lamp   = r_r.chan_alarm;
   assign o_chan_answer       = r_r.chan_answer;
   assign o_audible_alarm     = r_r.audible;
   assign o_ack_lamp          = r_r.ack_lamp;
   assign o_restart_lamp      = r_r.svc_lamp;
   assign o_alarm_lamp        = r_r.lamp_out;

   sequence s_status_clear;
      fsc_wr && is_code(code, ocp_pkg::FSC_GATE_OUT_STATUS);
   endsequence

   sequence s_matrix_code;
      fsc_wr && is_code(code, ocp_pkg::FSC_GATE_IN_ALARM);
   endsequence

   sequence s_matrix_word;
      word_wr ##0 r_r.matrix_armed;
   endsequence

   a_entry_both: assert property (@(posedge i_clock) disable iff (!i_rstn)
      o_entry_req |-> $past(both))
      else $error("entry request without both buttons held");
   a_entry_once: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (o_entry_req ##1 both [*3]) |-> !o_entry_req)
      else $error("second entry request while buttons stayed held");
   a_status_clr: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (s_status_clear ##0 !(sw.start && !r_r.prev.start) ##0 !both) |=>
      !r_r.start_cap && (r_r.snap == 2'b00) && !r_r.entry_pend)
      else $error("status select did not clear captured switches");
   a_start_via_entry: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      $rose(r_r.snap[0]) |-> o_entry_req)
      else $error("start reached software without an entry");
   a_stop_via_entry: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      $rose(r_r.snap[1]) |-> o_entry_req)
      else $error("stop reached software without an entry");
   a_monitor_fail: assert property (@(posedge i_clock) disable iff (!i_rstn)
      ((r_r.wdog_cnt == 32'(WDOG_CYCLES - 1)) &&
       !(sw.wdog_kick && !r_r.prev.wdog_kick)) |=>
      o_monitor_fail_lamp)
      else $error("watchdog expiry did not light monitor failure");
   a_chan_answer: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (sw.chan_fail[0] && !r_r.prev.chan_fail[0]) |=>
      o_chan_answer[0] && o_chan_alarm_lamp[0] ##1
      !o_chan_answer[0])
      else $error("channel monitor did not answer for the channel");
   a_chan_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (o_chan_alarm_lamp != 3'b000 && !sw.man_reset) |=>
      ((o_chan_alarm_lamp & $past(o_chan_alarm_lamp)) ==
       $past(o_chan_alarm_lamp)))
      else $error("channel alarm lamp dropped without manual reset");
   a_ack_clears: assert property (@(posedge i_clock) disable iff (!i_rstn)
      ((sw.ack && !alarm_set) ##1 !alarm_set) |-> !r_r.alarm_ff ##1
      !o_audible_alarm)
      else $error("acknowledge did not clear the alarm flip-flop");
   a_ack_lamp: assert property (@(posedge i_clock) disable iff (!i_rstn)
      o_ack_lamp == $past(i_ack_sw, 3))
      else $error("acknowledge lamp does not follow the held button");
   a_silence_mutes: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      sw.silence |=> !o_audible_alarm)
      else $error("audible alarm sounded while silenced");
   a_service_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (fsc_wr && is_code(code, ocp_pkg::FSC_GATE_IN_SERVICE)) |=>
      (r_r.svc_snap == $past(o_restart_lamp)))
      else $error("service select did not capture restart lamps");
   a_matrix_load: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (s_matrix_code ##1 (!wr) [*2] ##1 s_matrix_word) |=>
      r_r.load_stb && (r_r.word == $past(i_wb_dat[11:0])))
      else $error("alarm word after matrix select was not loaded");
   a_new_flash: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (r_r.load_stb && r_r.word[0] && !lamp_flash[0] && !lamp_steady[0])
      |=> lamp_flash[0] && r_r.alarm_ff)
      else $error("new alarm lamp did not start flashing");
   a_idle_lamp: assert property (@(posedge i_clock) disable iff (!i_rstn)
      sw.idle |=> o_restart_lamp[1])
      else $error("lines inactive lamp missed the idle status");
endmodule // ocp_top

//--- ocp_pkg.sv
package ocp_pkg;
   // 10 mhz system clock
   localparam int unsigned CLK_HZ          = 32'h0098_9680;
   localparam int unsigned WDOG_TIMEOUT_MS = 32'h0000_03e8;
   localparam int unsigned WDOG_CYCLES     =
      WDOG_TIMEOUT_MS * (CLK_HZ / 32'h0000_03e8);
   localparam int unsigned FLASH_HALF_MS   = 32'h0000_00fa;
   localparam int unsigned FLASH_CYCLES    =
      FLASH_HALF_MS * (CLK_HZ / 32'h0000_03e8);

   localparam int unsigned LAMP_W = 32'h0000_000c;
   localparam int unsigned CHAN_W = 32'h0000_0003;
   localparam int unsigned SEL_W  = 32'h0000_0010;

   localparam logic [7:0] ADR_FSC     = 8'h00;
   localparam logic [7:0] ADR_ALARM   = 8'h04;
   localparam logic [7:0] ADR_STATUS  = 8'h08;
   localparam logic [7:0] ADR_SERVICE = 8'h0c;
   localparam logic [7:0] ADR_SWITCH  = 8'h10;

   localparam logic [15:0] FSC_GATE_OUT_STATUS  = 16'h5600;
   localparam logic [15:0] FSC_GATE_IN_ALARM    = 16'h5640;
   localparam logic [15:0] FSC_GATE_IN_SERVICE  = 16'h5641;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      LAMP_OFF    = 3'b001,
      LAMP_FLASH  = 3'b010,
      LAMP_STEADY = 3'b100
   } ocp_lamp_st_t;

   typedef struct packed {
      logic              entry_l;
      logic              entry_r;
      logic              start;
      logic              stop;
      logic              ack;
      logic              silence;
      logic              man_reset;
      logic              wdog_kick;
      logic              idle;
      logic              svc_msg;
      logic              xfer_done;
      logic [11:0]       lamp_sw;
      logic [2:0]        chan_fail;
      logic [15:0]       sel;
   } ocp_panel_t;
endpackage

//--- ocp_sync.sv
`timescale 1ns/1ps
module ocp_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             i_clock,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ocp_sync_t;

   ocp_sync_t r_r;
   ocp_sync_t r_nxt;

   // the meta stage feeds only the sync stage
   always_comb begin
      r_nxt      = r_r;
      r_nxt.meta = i_d;
      r_nxt.sync = r_r.meta;
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign o_q = r_r.sync;
endmodule // ocp_sync

//--- ocp_lamp.sv
`timescale 1ns/1ps
module ocp_lamp (
   input  wire logic i_clock,
   input  wire logic i_rstn,
   input  wire logic i_clear,
   input  wire logic i_load,
   input  wire logic i_bit,
   input  wire logic i_press,
   input  wire logic i_blink,
   output logic      o_lit,
   output logic      o_flash,
   output logic      o_steady
);
   typedef struct packed {
      ocp_pkg::ocp_lamp_st_t st;
      logic                  asserted;
      logic                  lit;
   } ocp_cell_t;

   ocp_cell_t r_r;
   ocp_cell_t r_nxt;

   always_comb begin
      r_nxt = r_r;
      if (i_clear) begin
         r_nxt.asserted = 1'b0;
      end
      if (i_load) begin
         r_nxt.asserted = i_bit;
      end
      case (r_r.st)
         ocp_pkg::LAMP_OFF: begin
            if (i_load && i_bit) begin
               r_nxt.st = ocp_pkg::LAMP_FLASH;
            end
         end
         ocp_pkg::LAMP_FLASH: begin
            if (i_press) begin
               r_nxt.st = r_nxt.asserted ? ocp_pkg::LAMP_STEADY
                                         : ocp_pkg::LAMP_OFF;
            end
         end
         ocp_pkg::LAMP_STEADY: begin
            // refresh keeps it steady; only a load with a zero bit puts it out
            if (i_load && !i_bit) begin
               r_nxt.st = ocp_pkg::LAMP_OFF;
            end
         end
         default: begin
            r_nxt.st = ocp_pkg::LAMP_OFF;
         end
      endcase
      r_nxt.lit = (r_nxt.st == ocp_pkg::LAMP_STEADY) ||
                  ((r_nxt.st == ocp_pkg::LAMP_FLASH) && i_blink);
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         r_r <= '{st: ocp_pkg::LAMP_OFF, asserted: 1'b0, lit: 1'b0};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign o_lit    = r_r.lit;
   assign o_flash  = (r_r.st == ocp_pkg::LAMP_FLASH);
   assign o_steady = (r_r.st == ocp_pkg::LAMP_STEADY);

   a_flash_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (o_flash && !i_press) |=> o_flash)
      else $error("flashing lamp left flash without a press");
   a_press_result: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (o_flash && i_press && !i_load && !i_clear) |=>
      (o_steady == $past(r_r.asserted)) && !o_flash)
      else $error("pressed lamp took the wrong state");
   a_steady_noflash: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      o_steady |=> !o_flash)
      else $error("steady lamp went straight back to flashing");
endmodule // ocp_lamp

//--- ocp_prog.sv
`timescale 1ns/1ps
module ocp_prog (
   input  wire logic        i_clock,
   input  wire logic [31:0] i_rdat,
   input  wire logic        i_ack,
   output logic             o_cyc,
   output logic             o_stb,
   output logic             o_we,
   output logic      [7:0]  o_adr,
   output logic      [3:0]  o_sel,
   output logic      [31:0] o_dat
);
   int tmo_cnt = 0;
   initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clock);
      {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, 4'hf, d};
      do begin
         @(posedge i_clock);
         n++;
      end while (i_ack !== 1'b1 && n < 20);
      if (n >= 20) tmo_cnt++;
      q = i_rdat;
      {o_cyc, o_stb} <= 2'b00;
      // released data is inverted so a stale value never looks valid
      o_dat <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic fsc(input logic [15:0] c);
      wr(ocp_pkg::ADR_FSC, {16'h0000, c});
   endtask
   // selector words first, further switches only as needed
   task automatic on_entry(output logic [31:0] q);
      rd(ocp_pkg::ADR_SWITCH, q);
   endtask
   // bits carry alarms the program found itself
   task automatic refresh(input logic [11:0] v);
      fsc(ocp_pkg::FSC_GATE_IN_ALARM);
      wr(ocp_pkg::ADR_ALARM, {20'h00000, v});
   endtask
endmodule // ocp_prog

//--- ocp_top_tb.sv
`timescale 1ns/1ps
module ocp_top_tb;
   logic                clk = 1'b0, wk = 1'b0;
   logic                rstn, kick, cyc, stb, we, ack, ent, srq, mf, aud, akl;
   ocp_pkg::ocp_panel_t p;
   logic [7:0]          adr;
   logic [3:0]          sel;
   logic [31:0]         wd, rdt, q;
   logic [2:0]          cl, ca, rl;
   logic [11:0]         al, w;
   logic [15:0]         sv;
   // lamp matrix model: flashing, steady and last loaded alarm bits
   logic [11:0]         m_fl = '0, m_st = '0, m_as = '0;
   int                  error_cnt = 0, n_checks = 0;
   int                  ne = 0, ns = 0, na = 0, k;
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (kick) wk <= ~wk;
      if (ent === 1'b1) ne++;
      if (srq === 1'b1) ns++;
      if (ca !== 3'b000) na++;
   end
   ocp_top #(.WDOG_CYCLES(50), .FLASH_CYCLES(4)) ocp_top_inst (
      .i_clock(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd),
      .o_wb_dat(rdt), .o_wb_ack(ack), .i_entry_left(p.entry_l),
      .i_entry_right(p.entry_r), .i_start_sw(p.start), .i_stop_sw(p.stop),
      .i_ack_sw(p.ack), .i_silence_sw(p.silence),
      .i_manual_reset(p.man_reset), .i_wdog_kick(wk),
      .i_input_idle(p.idle), .i_service_msg(p.svc_msg),
      .i_transfer_done(p.xfer_done), .i_lamp_sw(p.lamp_sw),
      .i_chan_fail(p.chan_fail), .i_select_sw(p.sel), .o_entry_req(ent),
      .o_start_req(srq), .o_monitor_fail_lamp(mf),
      .o_chan_alarm_lamp(cl), .o_chan_answer(ca), .o_audible_alarm(aud),
      .o_ack_lamp(akl), .o_restart_lamp(rl), .o_alarm_lamp(al));
   ocp_prog pm (.i_clock(clk), .i_rdat(rdt), .i_ack(ack), .o_cyc(cyc),
      .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wd));
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic mat(input logic [11:0] v, input logic pr);
      pm.refresh(v);
      // dark lamps with a one start flashing; steady ones with a zero go out
      m_fl = m_fl | (v & ~m_st);
      m_st = m_st & v;
      m_as = v;
      cy(4);
      if (pr) begin
         p.lamp_sw <= 12'hfff;
         cy(6);
         p.lamp_sw <= 12'h000;
         cy(4);
         m_st = m_st | (m_fl & m_as);
         m_fl = 12'h000;
      end
      pm.rd(ocp_pkg::ADR_ALARM, q);
      chk("flash", {20'h0, m_fl}, {20'h0, q[27:16]});
      chk("steady", {20'h0, m_st}, {20'h0, q[11:0]});
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      p = '0;
      rstn = 1'b0;
      kick = 1'b1;
      k = $urandom(32'h1be2b62e);
      sv = 16'($urandom());
      w = 12'($urandom()) | 12'h001;
      k = $urandom_range(2, 0);
      cy(10);
      rstn <= 1'b1;
      cy(1);
      chk("lamps", 32'h0, al);
      {p.start, p.stop, p.entry_l, p.sel} <= {3'b111, sv};
      cy(8);
      chk("start_req", 32'h1, ns);
      chk("one_btn", 32'h0, ne);
      pm.rd(ocp_pkg::ADR_STATUS, q);
      chk("undeliv", 32'h0, q[1:0]);
      p.entry_r <= 1'b1;
      cy(12);
      chk("entry", 32'h1, ne);
      pm.on_entry(q);
      chk("switch", {16'h0, sv}, q);
      pm.rd(ocp_pkg::ADR_STATUS, q);
      chk("deliv", 32'h7, q[2:0]);
      p.entry_r <= 1'b0;
      cy(4);
      p.entry_r <= 1'b1;
      cy(8);
      chk("rearm", 32'h2, ne);
      {p.entry_l, p.entry_r, p.start, p.stop} <= 4'h0;
      // let the released buttons pass the synchroniser before the clear
      cy(4);
      pm.fsc(ocp_pkg::FSC_GATE_OUT_STATUS);
      pm.rd(ocp_pkg::ADR_STATUS, q);
      chk("clear", 32'h0, q[2:0]);
      p.chan_fail <= 3'b001 | 3'(1 << k);
      cy(6);
      chk("answer", 32'h1, na);
      pm.wr(ocp_pkg::ADR_STATUS, 32'h0);
      chk("chan", 32'(3'b001 | 3'(1 << k)), cl);
      {p.man_reset, p.chan_fail} <= 4'h8;
      cy(6);
      chk("chan_rst", 32'h0, cl);
      p.man_reset <= 1'b0;
      p.ack <= 1'b1;
      cy(6);
      chk("horn_ack", 32'h0, aud);
      chk("ack_lamp", 32'h1, akl);
      p.ack <= 1'b0;
      cy(6);
      chk("ack_off", 32'h0, akl);
      mat(w, 1'b0);
      chk("horn", 32'h1, aud);
      p.silence <= 1'b1;
      cy(6);
      chk("mute", 32'h0, aud);
      p.silence <= 1'b0;
      mat(w, 1'b1);
      chk("lamp_out", {20'h0, w}, {20'h0, al});
      mat(w, 1'b0);
      mat(12'h0, 1'b0);
      mat(w, 1'b0);
      mat(12'h0, 1'b1);
      pm.wr(ocp_pkg::ADR_ALARM, 32'h0000_0fff);
      pm.rd(ocp_pkg::ADR_ALARM, q);
      chk("unarmed", 32'h0, q);
      {p.xfer_done, p.idle, p.svc_msg} <= {k[0], 2'b11};
      cy(6);
      chk("restart", {29'h0, k[0], 2'b11}, rl);
      pm.fsc(ocp_pkg::FSC_GATE_IN_SERVICE);
      pm.rd(ocp_pkg::ADR_SERVICE, q);
      chk("service", {29'h0, k[0], 2'b11}, q);
      pm.rd(8'hfc, q);
      chk("unmapped", 32'h0, q);
      kick <= 1'b0;
      cy(80);
      chk("mon_fail", 32'h1, mf);
      kick <= 1'b1;
      cy(10);
      chk("mon_ok", 32'h0, mf);
      error_cnt += pm.tmo_cnt;
      end_sim();
   end
endmodule // ocp_top_tb
